// file: common/frc_regs.svh
// Constants for the flash reset, unique-id and parameter-space commands
`ifndef FRC_REGS_SVH
`define FRC_REGS_SVH

// Opcodes
`define FRC_OP_NOP 8'h00
`define FRC_OP_ARM 8'h66
`define FRC_OP_RST 8'h99
`define FRC_OP_UID 8'h4b
`define FRC_OP_PRM 8'h5a

// Phase lengths in bits, minus one; id data length in bytes
`define FRC_CMD_LAST 6'h07
`define FRC_ADDR_LAST 6'h17
`define FRC_UID_DUMMY_LAST 6'h1f
`define FRC_PRM_DUMMY_LAST 6'h07
`define FRC_UID_BYTES 24'h000010

// Parameter-space header bytes
`define FRC_SIG0 8'h53
`define FRC_SIG1 8'h46
`define FRC_SIG2 8'h44
`define FRC_SIG3 8'h50
`define FRC_REV_MINOR 8'h00
`define FRC_REV_MAJOR 8'h01
`define FRC_NUM_HDR 8'h01
`define FRC_UNUSED 8'hff
`define FRC_STD_ID 8'h00
`define FRC_TAB_MINOR 8'h00
`define FRC_TAB_MAJOR 8'h01
`define FRC_STD_LEN 8'h09
`define FRC_STD_PTR0 8'h30
`define FRC_VND_LEN 8'h03
`define FRC_VND_PTR0 8'h60
`define FRC_PTR_HI 8'h00

// Reset recovery time
`define FRC_T_RCV_NS 1000
`define FRC_CLK_MHZ 50
`define FRC_RCV_CYC ((`FRC_T_RCV_NS * `FRC_CLK_MHZ + 999) / 1000)

`endif

// file: common/frc_pkg.sv
// Types for the flash reset, unique-id and parameter-space commands
package frc_pkg;
   typedef enum logic [5:0] {
      FRC_IDLE  = 6'b000001,
      FRC_CMD   = 6'b000010,
      FRC_ADDR  = 6'b000100,
      FRC_DUMMY = 6'b001000,
      FRC_DATA  = 6'b010000,
      FRC_SKIP  = 6'b100000
   } frc_state_e;
endpackage

// file: core/frc_core.sv
// Serial command logic: no-op, software reset, unique id, parameter space
`timescale 1ns/1ps
`include "frc_regs.svh"

// What this block does
// RULE1 - A no-op only cancels a pending reset-arm, nothing else.
// RULE2 - No-op, arm and execute take opcode from serial input only.
// RULE3 - Software reset is arm then execute; device then returns to standby.
// RULE4 - A completed software reset restores all volatile state to power-on.
// RULE5 - Execute acts only right after arm; any other command cancels the arm.
// RULE6 - Reset during program or erase aborts it; its data may be corrupted.
// RULE7 - A read-only factory 128-bit identifier unique to every part.
// RULE8 - Id read: opcode 4B, four dummy bytes, then 128 identifier bits out.
// RULE9 - Parameter read: opcode 5A, three address bytes, one dummy, data.
// RULE10 - Chip select high during parameter data stops output, ends command.
// RULE11 - Bytes 00 to 03 read 53, 46, 44, 50.
// RULE12 - Byte 04 reads minor revision 00, byte 05 major revision 01.
// RULE13 - Byte 06 reads 01: two parameter headers, counted from zero.
// RULE14 - Bytes 07, 0F and 17 always read FF and cannot be written.
// RULE15 - First header: id 00 at 08, revision 00 and 01 at 09, 0A.
// RULE16 - Byte 0B reads 09, the standard table length in 32-bit words.
// RULE17 - First table pointer stored low byte first: 30, 00, 00.
// RULE18 - Second header: maker code, revision 00 01, length 03, pointer 60.
// RULE19 - Arm and execute are accepted at any time during a suspend.
// RULE20 - Parameter read address increments after every output byte.
// RULE21 - Host waits a recovery interval after reset; length is a parameter.
module frc_core #(
   // Arbitrary per-part value
   parameter logic [127:0] UNIQUE_ID = 128'h0123456789abcdeffedcba9876543210,
   // Arbitrary maker code
   parameter logic [7:0] MAKER_ID = 8'hc3
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Serial link pins
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic si_i,
   input wire logic [2:0] upper_io_i,
   output logic so_o,
   output logic so_oe_o,
   // Program and erase engine
   input wire logic pe_busy_i,
   output logic pe_abort_o,
   output logic soft_reset_o,
   output logic reset_busy_o,
   output logic reset_armed_o
);

   // Pin synchronisers
   logic [1:0] cs_s;
   logic [1:0] ck_s;
   logic [1:0] si_s;
   logic cs_d;
   logic ck_d;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_s <= 2'h3;
         ck_s <= 2'h0;
         si_s <= 2'h0;
         cs_d <= 1'b1;
         ck_d <= 1'b0;
      end else begin
         cs_s <= {cs_s[0], cs_n_i};
         ck_s <= {ck_s[0], sclk_i};
         si_s <= {si_s[0], si_i};
         cs_d <= cs_s[1];
         ck_d <= ck_s[1];
      end
   end

   wire cs_act = ~cs_s[1];
   wire cs_fall = ~cs_s[1] & cs_d;
   wire ck_rise = ck_s[1] & ~ck_d;
   wire ck_fall = ~ck_s[1] & ck_d;
   // Upper lines are never read for any command here [RULE2]
   wire unused_io = ^upper_io_i;

   // Command state
   frc_pkg::frc_state_e state;
   frc_pkg::frc_state_e next_state;
   logic [5:0] bit_cnt;
   logic [5:0] next_cnt;
   logic [7:0] rx;
   logic cmd_uid;
   logic armed;
   logic [23:0] addr;
   logic [15:0] rcv_cnt;

   wire [7:0] next_rx = {rx[6:0], si_s[1]};
   wire op_done = (state == frc_pkg::FRC_CMD) && ck_rise &&
                  (bit_cnt == `FRC_CMD_LAST);
   // Opcode is taken from the serial input alone [RULE2]
   wire op_arm = op_done && (next_rx == `FRC_OP_ARM);
   wire op_nop = op_done && (next_rx == `FRC_OP_NOP);
   wire op_uid = op_done && (next_rx == `FRC_OP_UID);
   wire op_prm = op_done && (next_rx == `FRC_OP_PRM);
   // Suspend state is not consulted here [RULE19]
   wire exec_hit = op_done && (next_rx == `FRC_OP_RST) && armed; // [RULE5]
   wire addr_last = (state == frc_pkg::FRC_ADDR) && ck_rise &&
                    (bit_cnt == `FRC_ADDR_LAST);
   wire [5:0] dummy_end = cmd_uid ? `FRC_UID_DUMMY_LAST
                                  : `FRC_PRM_DUMMY_LAST;
   wire dummy_last = (state == frc_pkg::FRC_DUMMY) && ck_rise &&
                     (bit_cnt == dummy_end);
   wire recovering = (rcv_cnt != 16'h0000);

   always_comb begin
      next_state = state;
      next_cnt = ck_rise ? bit_cnt + 6'h01 : bit_cnt;
      unique case (state)
         frc_pkg::FRC_IDLE: begin
            next_cnt = 6'h00;
            // Commands begun during the recovery interval are ignored [RULE21]
            if (cs_fall && !recovering) begin
               next_state = frc_pkg::FRC_CMD;
            end
         end
         frc_pkg::FRC_CMD: begin
            if (op_done) begin
               next_cnt = 6'h00;
               if (op_uid) begin
                  next_state = frc_pkg::FRC_DUMMY; // [RULE8]
               end else if (op_prm) begin
                  next_state = frc_pkg::FRC_ADDR; // [RULE9]
               end else begin
                  next_state = frc_pkg::FRC_SKIP;
               end
            end
         end
         frc_pkg::FRC_ADDR: begin
            if (addr_last) begin
               next_cnt = 6'h00;
               next_state = frc_pkg::FRC_DUMMY;
            end
         end
         frc_pkg::FRC_DUMMY: begin
            if (dummy_last) begin
               next_state = frc_pkg::FRC_DATA;
            end
         end
         frc_pkg::FRC_DATA: begin
            next_cnt = bit_cnt;
         end
         frc_pkg::FRC_SKIP: begin
            next_cnt = bit_cnt;
         end
         default: begin
            next_state = frc_pkg::FRC_IDLE;
         end
      endcase
      // Chip select high or a reset returns to standby [RULE3] [RULE10]
      if (!cs_act || exec_hit) begin
         next_state = frc_pkg::FRC_IDLE;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= frc_pkg::FRC_IDLE;
         bit_cnt <= 6'h00;
         rx <= 8'h00;
      end else begin
         state <= next_state;
         bit_cnt <= next_cnt;
         rx <= ck_rise ? next_rx : rx;
      end
   end

   // Arm latch: any completed opcode other than arm cancels it
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         armed <= 1'b0;
         cmd_uid <= 1'b0;
      end else begin
         if (op_done) begin
            armed <= op_arm; // [RULE1] [RULE5]
            cmd_uid <= op_uid;
         end
      end
   end

   // Reset pulses and recovery counter
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         soft_reset_o <= 1'b0;
         pe_abort_o <= 1'b0;
         rcv_cnt <= 16'h0000;
      end else begin
         soft_reset_o <= exec_hit; // [RULE3]
         pe_abort_o <= exec_hit & pe_busy_i; // [RULE6]
         if (exec_hit) begin
            rcv_cnt <= 16'(`FRC_RCV_CYC); // [RULE21]
         end else if (recovering) begin
            rcv_cnt <= rcv_cnt - 16'h0001;
         end
      end
   end

   assign reset_busy_o = recovering;
   assign reset_armed_o = armed;

   // Byte source: address or id byte index
   logic [7:0] prm_byte;
   wire uid_more = addr < `FRC_UID_BYTES;
   wire [3:0] uid_idx = 4'hf - addr[3:0];
   // Fixed factory value, no write path [RULE7]
   wire [7:0] uid_byte = UNIQUE_ID[{uid_idx, 3'h0} +: 8];
   wire src_valid = (state == frc_pkg::FRC_DATA) &&
                    (!cmd_uid || uid_more);
   wire [7:0] src_byte = cmd_uid ? uid_byte : prm_byte;
   logic f_wr_ready;
   wire push = src_valid && f_wr_ready;

   always_comb begin
      unique case (addr)
         24'h000000: prm_byte = `FRC_SIG0; // [RULE11]
         24'h000001: prm_byte = `FRC_SIG1; // [RULE11]
         24'h000002: prm_byte = `FRC_SIG2; // [RULE11]
         24'h000003: prm_byte = `FRC_SIG3; // [RULE11]
         24'h000004: prm_byte = `FRC_REV_MINOR; // [RULE12]
         24'h000005: prm_byte = `FRC_REV_MAJOR; // [RULE12]
         24'h000006: prm_byte = `FRC_NUM_HDR; // [RULE13]
         24'h000008: prm_byte = `FRC_STD_ID; // [RULE15]
         24'h000009: prm_byte = `FRC_TAB_MINOR; // [RULE15]
         24'h00000a: prm_byte = `FRC_TAB_MAJOR; // [RULE15]
         24'h00000b: prm_byte = `FRC_STD_LEN; // [RULE16]
         24'h00000c: prm_byte = `FRC_STD_PTR0; // [RULE17]
         24'h00000d: prm_byte = `FRC_PTR_HI; // [RULE17]
         24'h00000e: prm_byte = `FRC_PTR_HI; // [RULE17]
         24'h000010: prm_byte = MAKER_ID; // [RULE18]
         24'h000011: prm_byte = `FRC_TAB_MINOR; // [RULE18]
         24'h000012: prm_byte = `FRC_TAB_MAJOR; // [RULE18]
         24'h000013: prm_byte = `FRC_VND_LEN; // [RULE18]
         24'h000014: prm_byte = `FRC_VND_PTR0; // [RULE18]
         24'h000015: prm_byte = `FRC_PTR_HI; // [RULE18]
         24'h000016: prm_byte = `FRC_PTR_HI; // [RULE18]
         // Unused bytes 07, 0F, 17 and beyond read FF [RULE14]
         default: prm_byte = `FRC_UNUSED;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr <= 24'h000000;
      end else if (op_done) begin
         addr <= 24'h000000;
      end else if (state == frc_pkg::FRC_ADDR && ck_rise) begin
         addr <= {addr[22:0], si_s[1]}; // [RULE9]
      end else if (push) begin
         addr <= addr + 24'h000001; // [RULE20]
      end
   end

   // Two-entry buffer between byte source and shifter
   logic [7:0] f_mem [2];
   logic f_wp;
   logic f_rp;
   logic [1:0] f_cnt;
   logic [7:0] sh;
   logic [2:0] sh_cnt;

   wire f_clr = (state != frc_pkg::FRC_DATA);
   wire f_rd_valid = (f_cnt != 2'h0);
   wire [7:0] f_head = f_mem[f_rp];
   wire need = ck_fall && !f_clr && (sh_cnt == 3'h0);
   wire pop = need && f_rd_valid;
   assign f_wr_ready = (f_cnt != 2'h2);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         f_wp <= 1'b0;
         f_rp <= 1'b0;
         f_cnt <= 2'h0;
      end else if (f_clr) begin
         f_wp <= 1'b0; // [RULE4]
         f_rp <= 1'b0;
         f_cnt <= 2'h0;
      end else begin
         f_wp <= f_wp ^ push;
         f_rp <= f_rp ^ pop;
         f_cnt <= f_cnt + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         f_mem[f_wp] <= src_byte;
      end
   end

   // Output shifter, MSB first on falling clock edges
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh <= 8'hff;
         sh_cnt <= 3'h0;
         so_o <= 1'b0;
      end else if (f_clr) begin
         sh <= 8'hff;
         sh_cnt <= 3'h0;
      end else if (pop) begin
         so_o <= f_head[7]; // [RULE8] [RULE9]
         sh <= {f_head[6:0], 1'b1};
         sh_cnt <= 3'h7;
      end else if (need) begin
         so_o <= 1'b1;
      end else if (ck_fall) begin
         so_o <= sh[7];
         sh <= {sh[6:0], 1'b1};
         sh_cnt <= sh_cnt - 3'h1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         so_oe_o <= 1'b0;
      end else begin
         // Drive stops as soon as chip select rises [RULE10]
         so_oe_o <= (state == frc_pkg::FRC_DATA) && cs_act;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_exec;
      exec_hit;
   endsequence

   sequence s_standby;
      (state == frc_pkg::FRC_IDLE && reset_busy_o) [*3];
   endsequence

   property p_nop_cancels;
      op_nop |=> !armed;
   endproperty
   a_nop_cancels: assert property (p_nop_cancels) // [RULE1]
      else $error("no-op left reset armed");

   property p_exec_standby;
      s_exec |=> s_standby;
   endproperty
   a_exec_standby: assert property (p_exec_standby) // [RULE3]
      else $error("reset did not return to standby");

   property p_reset_clears;
      soft_reset_o |-> !armed && f_cnt == 2'h0 && !so_oe_o;
   endproperty
   a_reset_clears: assert property (p_reset_clears) // [RULE4]
      else $error("volatile state survived reset");

   property p_exec_needs_arm;
      soft_reset_o |-> $past(armed);
   endproperty
   a_exec_needs_arm: assert property (p_exec_needs_arm) // [RULE5]
      else $error("reset executed without arm");

   property p_other_cancels;
      op_done && !op_arm |=> !armed;
   endproperty
   a_other_cancels: assert property (p_other_cancels) // [RULE5]
      else $error("arm survived another command");

   property p_abort;
      pe_abort_o |-> soft_reset_o && $past(pe_busy_i);
   endproperty
   a_abort: assert property (p_abort) // [RULE6]
      else $error("abort without reset during busy");

   property p_cs_stops;
      $rose(cs_s[1]) |-> ##[1:2] !so_oe_o;
   endproperty
   a_cs_stops: assert property (p_cs_stops) // [RULE10]
      else $error("output still driven after chip select");

   property p_signature;
      push && !cmd_uid && addr == 24'h000000 |-> src_byte == 8'h53;
   endproperty
   a_signature: assert property (p_signature) // [RULE11]
      else $error("wrong signature byte");

   property p_major;
      push && !cmd_uid && addr == 24'h000005 |-> src_byte == 8'h01;
   endproperty
   a_major: assert property (p_major) // [RULE12]
      else $error("wrong major revision");

   property p_addr_inc;
      push && !cmd_uid |=> addr == $past(addr) + 24'h000001;
   endproperty
   a_addr_inc: assert property (p_addr_inc) // [RULE20]
      else $error("address did not advance");

   property p_no_overflow;
      f_cnt != 2'h3;
   endproperty
   a_no_overflow: assert property (p_no_overflow)
      else $error("buffer written while full");

endmodule

// file: tb/frc_host.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module frc_host (
   // Serial link pins
   output logic cs_n_o,
   output logic sclk_o,
   output logic si_o,
   input wire logic so_i
);
   localparam time HALF = 80ns;

   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o = 1'b0;
   end

   // One frame: ntx bits out MSB first, then nrx bits captured
   task automatic frame(input logic [39:0] tx, input int ntx,
                        input int nrx, output logic [191:0] rx);
      rx = '1;
      #3;
      cs_n_o = 1'b0;
      for (int i = 0; i < ntx + nrx; i++) begin
         if (i < ntx) begin
            si_o = tx[39 - i];
         end else begin
            si_o = ~si_o;
         end
         #HALF;
         sclk_o = 1'b1;
         #HALF;
         // Sample late in the high phase, well clear of the next change
         if (i >= ntx) begin
            rx = {rx[190:0], so_i};
         end
         sclk_o = 1'b0;
      end
      #HALF;
      cs_n_o = 1'b1;
      si_o = ~si_o;
      #200;
   endtask
endmodule

// file: tb/tb_top.sv
// Testbench for the serial reset, id and parameter commands
`timescale 1ns/1ps
`include "frc_regs.svh"
module tb_top;
   // Arbitrary id and maker values
   localparam logic [127:0] UID = 128'h5a5a0f0f3c3cc3c3a5a5f0f01e1ee1e1;
   localparam logic [7:0] MAKER = 8'h5e;

   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] upper_io_i = 3'b000;
   logic pe_busy_i = 1'b0;
   logic cs_n, sclk, si, so_o, so_oe_o, so_line;
   logic pe_abort_o, soft_reset_o, reset_busy_o, reset_armed_o;
   logic [191:0] rx;
   int num_errors = 0;
   int total_checks = 0;
   int n_soft = 0;
   int n_abort = 0;
   int n_busy = 0;

   // Pulled-up data line
   assign so_line = so_oe_o ? so_o : 1'b1;

   frc_core #(.UNIQUE_ID(UID), .MAKER_ID(MAKER)) i_frc_core (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
      .sclk_i(sclk), .si_i(si), .upper_io_i(upper_io_i), .so_o(so_o),
      .so_oe_o(so_oe_o), .pe_busy_i(pe_busy_i), .pe_abort_o(pe_abort_o),
      .soft_reset_o(soft_reset_o), .reset_busy_o(reset_busy_o),
      .reset_armed_o(reset_armed_o));

   frc_host i_frc_host (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
      .so_i(so_line));

   always #10 ref_clk_i = ~ref_clk_i;

   // Count pulses and recovery cycles
   always @(negedge ref_clk_i) begin
      if (soft_reset_o === 1'b1) n_soft++;
      if (pe_abort_o === 1'b1) n_abort++;
      if (reset_busy_o === 1'b1) n_busy++;
   end

   task automatic chk(input string what, input logic [191:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic send_op(input logic [7:0] op);
      i_frc_host.frame({op, 32'h0}, 8, 0, rx);
      @(negedge ref_clk_i);
   endtask

   task automatic t_idle_values();
      chk("oe", 192'(so_oe_o), 192'h0);
      chk("armed", 192'(reset_armed_o), 192'h0);
      chk("busy", 192'(reset_busy_o), 192'h0);
   endtask

   task automatic t_param();
      i_frc_host.frame({8'h5a, 24'h0, 8'h0}, 40, 192, rx);
      chk("hdr", rx, {32'h53464450, 32'h000101ff, 32'h00000109,
         32'h300000ff, MAKER, 24'h000103, 32'h600000ff});
      // Line above
      // Same
      i_frc_host.frame({8'h5a, 24'h000016, 8'h0}, 40, 20, rx);
      chk("early end", 192'(rx[19:0]), 192'h00fff);
      @(negedge ref_clk_i);
      chk("oe after end", 192'(so_oe_o), 192'h0);
      i_frc_host.frame({8'h5a, 24'h00000c, 8'h0}, 40, 32, rx);
      chk("pointer", 192'(rx[31:0]), 192'h300000ff);
   endtask

   task automatic t_uid();
      @(negedge ref_clk_i);
      upper_io_i = 3'b101;
      i_frc_host.frame({8'h4b, 32'h0}, 40, 128, rx);
      chk("uid", 192'(rx[127:0]), 192'(UID));
   endtask

   task automatic t_reset(input logic busy);
      int s0, a0, b0;
      s0 = n_soft;
      a0 = n_abort;
      b0 = n_busy;
      @(negedge ref_clk_i);
      pe_busy_i = busy;
      upper_io_i = 3'b111;
      send_op(`FRC_OP_ARM);
      chk("armed", 192'(reset_armed_o), 192'h1);
      send_op(`FRC_OP_RST);
      chk("soft", 192'(n_soft - s0), 192'h1);
      chk("abort", 192'(n_abort - a0), 192'(busy));
      chk("disarmed", 192'(reset_armed_o), 192'h0);
      // Host waits out recovery before any new frame
      for (int i = 0; i < 300 && reset_busy_o !== 1'b0; i++) begin
         @(negedge ref_clk_i);
      end
      chk("recovery", 192'(n_busy - b0), 192'(`FRC_RCV_CYC));
      pe_busy_i = 1'b0;
      upper_io_i = 3'b000;
   endtask

   task automatic t_cancel();
      logic [7:0] ops [2];
      int s0;
      ops = '{`FRC_OP_NOP, `FRC_OP_UID};
      for (int k = 0; k < 2; k++) begin
         s0 = n_soft;
         send_op(`FRC_OP_ARM);
         chk("armed", 192'(reset_armed_o), 192'h1);
         send_op(ops[k]);
         chk("cancel", 192'(reset_armed_o), 192'h0);
         send_op(`FRC_OP_RST);
         chk("no reset", 192'(n_soft - s0), 192'h0);
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      #500us;
      num_errors++;
      end_of_test();
   end

   initial begin
      repeat (2) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      t_idle_values();
      t_param();
      t_uid();
      t_reset(1'b1);
      t_uid();
      t_cancel();
      t_param();
      t_reset(1'b0);
      end_of_test();
   end
endmodule
